/* bench/instruction_cycle_timing_test.sv */
// Self-checking bench of the core: runs small programs from the memory model
// and judges cycle counts, accumulator and flags.
// Assumes the core's default program counter width of 12 bits.
`timescale 1ns/1ps
module instruction_cycle_timing_test;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic [11:0] prog_addr;
  logic [15:0] prog_data;
  logic cycle_end;
  logic [7:0] acc;
  core_pkg::flags_t flags;
  logic int_en;
  logic [1:0] ph = 2'h0;
  int failures = 0;
  int tests_run = 0;
  int ticks = 0;

  always #2.5 CLK = ~CLK;

  cycle_core cycle_core_i (.CLK(CLK), .RST_N(RST_N), .PROG_ADDR(prog_addr),
    .PROG_DATA(prog_data), .CYCLE_END(cycle_end), .ACC(acc), .FLAGS(flags),
    .INT_EN(int_en));
  prog_rom prog_rom_i (.clk(CLK), .addr(prog_addr), .data(prog_data));

  //////////////////////////////////////////////////////////////////////////////
  // Reference phase count and hang guard
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ph <= 2'h0;
    end else begin
      ph <= ph + 2'h1;
    end
  end

  // Read at the edge, before the core's updates land
  always @(posedge CLK) begin
    ticks++;
    if (RST_N) begin
      tests_run++;
      if (cycle_end !== (ph == 2'h3)) begin
        failures++;
        $display("[FAIL] cycle_end expected %b seen %b", ph == 2'h3, cycle_end);
      end
    end
    if (ticks == 10000) begin
      failures++;
      complete_run();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic complete_run();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic clr();
    for (int i = 0; i < 4096; i++) begin
      prog_rom_i.words[i] = 16'h0000;
    end
  endtask

  task automatic ld(input int a, input core_pkg::op_t op, input logic [11:0] f);
    prog_rom_i.words[a] = {op, f};
  endtask

  // Reset, then count instruction cycles until address h is first fetched;
  // the fetch of h lands in the same cycle in which the instruction before it executes.
  task automatic go(input logic [11:0] h, input int cyc, input logic [7:0] a,
                    input logic [1:0] f);
    int n;
    int w;
    @(negedge CLK);
    RST_N = 1'b0;
    repeat (6) @(negedge CLK);
    RST_N = 1'b1;
    n = 0;
    w = 0;
    while (!(ph == 2'h2 && prog_addr === h) && w < 400) begin
      @(negedge CLK);
      if (cycle_end === 1'b1) begin
        n++;
      end
      w++;
    end
    check("fetch seen", 16'h0001, {15'h0000, w < 400});
    check("cycles", 16'(cyc), 16'(n));
    repeat (2) @(negedge CLK);
    check("acc", {8'h00, a}, {8'h00, acc});
    check("flags", {14'h0000, f}, {14'h0000, flags});
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_add();
    clr();
    ld(0, core_pkg::OP_MOVI, 12'h0f0);
    ld(1, core_pkg::OP_MOV, 12'h810);
    ld(2, core_pkg::OP_MOVI, 12'h020);
    ld(3, core_pkg::OP_ADD, 12'h010);
    go(12'h004, 4, 8'h10, 2'b01);
  endtask

  task automatic t_sub();
    clr();
    ld(0, core_pkg::OP_MOVI, 12'h010);
    ld(1, core_pkg::OP_MOV, 12'h810);
    ld(2, core_pkg::OP_MOVI, 12'h005);
    ld(3, core_pkg::OP_SUB, 12'h010);
    ld(4, core_pkg::OP_INCDEC, 12'h010);
    ld(5, core_pkg::OP_INCDEC, 12'h110);
    go(12'h004, 4, 8'hf5, 2'b01);
    go(12'h005, 5, 8'h11, 2'b01);
    go(12'h006, 6, 8'h0f, 2'b01);
  endtask

  task automatic t_logic();
    clr();
    ld(0, core_pkg::OP_MOVI, 12'h0ff);
    ld(1, core_pkg::OP_MOV, 12'h820);
    ld(2, core_pkg::OP_MOVI, 12'h000);
    ld(3, core_pkg::OP_LOGIC, 12'h020);
    ld(4, core_pkg::OP_LOGIC, 12'h220);
    ld(5, core_pkg::OP_LOGIC, 12'h320);
    ld(6, core_pkg::OP_LOGIC, 12'h120);
    go(12'h004, 4, 8'h00, 2'b10);
    go(12'h005, 5, 8'hff, 2'b00);
    go(12'h006, 6, 8'h00, 2'b10);
    go(12'h007, 7, 8'hff, 2'b00);
  endtask

  task automatic t_rot();
    clr();
    ld(0, core_pkg::OP_MOVI, 12'h081);
    ld(1, core_pkg::OP_MOV, 12'h830);
    ld(2, core_pkg::OP_ROT, 12'h230);
    ld(3, core_pkg::OP_ROT, 12'h330);
    ld(4, core_pkg::OP_ROT, 12'h030);
    ld(5, core_pkg::OP_ROT, 12'h130);
    go(12'h003, 3, 8'h40, 2'b01);
    go(12'h004, 4, 8'h03, 2'b01);
    go(12'h005, 5, 8'hc0, 2'b01);
    go(12'h006, 6, 8'h03, 2'b01);
  endtask

  task automatic t_bits();
    clr();
    ld(0, core_pkg::OP_MOVI, 12'h0a5);
    ld(1, core_pkg::OP_MOV, 12'h840);
    ld(2, core_pkg::OP_BCLR, 12'h840);
    ld(3, core_pkg::OP_BSET, 12'he40);
    ld(4, core_pkg::OP_MOV, 12'h040);
    go(12'h005, 5, 8'he4, 2'b00);
  endtask

  task automatic t_skip();
    clr();
    ld(0, core_pkg::OP_MOVI, 12'h000);
    ld(1, core_pkg::OP_MOV, 12'h850);
    ld(2, core_pkg::OP_SZ, 12'h050);
    ld(3, core_pkg::OP_MOVI, 12'h011);
    ld(5, core_pkg::OP_SNZ, 12'h050);
    ld(6, core_pkg::OP_MOVI, 12'h033);
    ld(7, core_pkg::OP_SBIT, 12'h350);
    ld(8, core_pkg::OP_MOVI, 12'h044);
    go(12'h005, 5, 8'h00, 2'b00);
    go(12'h007, 7, 8'h33, 2'b00);
    go(12'h00a, 10, 8'h33, 2'b00);
  endtask

  // Call, return, jump, low-byte write and interrupt return back to back
  task automatic t_flow();
    clr();
    ld(0, core_pkg::OP_CALL, 12'h020);
    ld(1, core_pkg::OP_MOVI, 12'h054);
    ld(2, core_pkg::OP_JUMP, 12'h040);
    ld(32, core_pkg::OP_MOVI, 12'h011);
    ld(33, core_pkg::OP_SYS, 12'h000);
    ld(64, core_pkg::OP_MOV, 12'h802);
    ld(84, core_pkg::OP_CALL, 12'h060);
    ld(96, core_pkg::OP_SYS, 12'h001);
    go(12'h056, 15, 8'h54, 2'b00);
    check("int_en", 16'h0001, {15'h0000, int_en});
  endtask

  task automatic t_table();
    clr();
    ld(0, core_pkg::OP_MOVI, 12'h070);
    ld(1, core_pkg::OP_MOV, 12'h803);
    ld(2, core_pkg::OP_SYS, 12'h012);
    ld(3, core_pkg::OP_MOV, 12'h012);
    ld(4, core_pkg::OP_MOV, 12'h004);
    prog_rom_i.words[112] = 16'hbeef;
    go(12'h004, 5, 8'hef, 2'b00);
    go(12'h005, 6, 8'hbe, 2'b00);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(negedge CLK);
    check("reset acc", 16'h0000, {8'h00, acc});
    check("reset addr", 16'h0000, {4'h0, prog_addr});
    check("reset int_en", 16'h0000, {15'h0000, int_en});
    t_add();
    t_sub();
    t_logic();
    t_rot();
    t_bits();
    t_skip();
    t_flow();
    t_table();
    complete_run();
  end
endmodule

/* bench/prog_rom.sv */
// Program memory model standing in front of the core's fetch port.
// Assumes the bench fills the word array before it releases the core's reset.
`timescale 1ns/1ps
module prog_rom #(
  parameter int unsigned AW = 12
) (
  input wire logic clk, // Core clock
  input wire logic [AW-1:0] addr, // Word address from the core
  output logic [15:0] data // Word addressed at the previous edge
);
  logic [15:0] words [0:(1<<AW)-1];

  // One clock of latency: table words and instruction words come back alike
  always_ff @(posedge clk) begin
    data <= words[addr];
  end
endmodule

/* rtl/core_pkg.sv */
// Shared constants and types of the 8-bit core: instruction layout,
// opcodes, special data addresses and reset values.
// Assumes a synchronous program memory with one clock of read latency.
package core_pkg;

  localparam int unsigned PHASES = 4;
  localparam logic [1:0] PHASE_FIRST = 2'h0;
  localparam logic [1:0] PHASE_TBL_DONE = 2'h1;
  localparam logic [1:0] PHASE_FETCH = 2'h2;
  localparam logic [1:0] PHASE_LAST = 2'h3;

  // Special data addresses decoded by the core instead of the RAM
  localparam logic [7:0] PC_LOW_ADDR = 8'h02;
  localparam logic [7:0] TBLP_ADDR = 8'h03;
  localparam logic [7:0] TBLH_ADDR = 8'h04;

  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] TBLP_RESET = 8'h00;
  localparam logic [7:0] TBLH_RESET = 8'h00;
  localparam logic INT_EN_RESET = 1'b0;

  // Sub-operation codes: logic and rotate in the bit-index field, system ops in the low bits of m
  localparam logic [1:0] LOG_AND = 2'h0;
  localparam logic [1:0] LOG_OR = 2'h1;
  localparam logic [1:0] LOG_XOR = 2'h2;
  localparam logic [1:0] LOG_CPL = 2'h3;
  localparam logic [1:0] ROT_RR = 2'h0;
  localparam logic [1:0] ROT_RL = 2'h1;
  localparam logic [1:0] ROT_RR_CARRY = 2'h2;
  localparam logic [1:0] ROT_RL_CARRY = 2'h3;
  localparam logic [3:0] SYS_RETURN = 4'h0;
  localparam logic [3:0] SYS_INT_RETURN = 4'h1;
  localparam logic [3:0] SYS_TABRD = 4'h2;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_MOV = 4'h1,
    OP_MOVI = 4'h2,
    OP_ADD = 4'h3,
    OP_SUB = 4'h4,
    OP_LOGIC = 4'h5,
    OP_INCDEC = 4'h6,
    OP_ROT = 4'h7,
    OP_BCLR = 4'h8,
    OP_BSET = 4'h9,
    OP_SZ = 4'ha,
    OP_SNZ = 4'hb,
    OP_SBIT = 4'hc,
    OP_JUMP = 4'hd,
    OP_CALL = 4'he,
    OP_SYS = 4'hf
  } op_t;

  // dest: 0 = accumulator, 1 = data memory; sub holds bit index or sub-op
  typedef struct packed {
    op_t op;
    logic dest;
    logic [2:0] sub;
    logic [7:0] m;
  } instr_t;

  typedef struct packed {
    logic zero;
    logic carry;
  } flags_t;

endpackage

/* rtl/cycle_core.sv */
// Instruction sequencer and datapath of the 8-bit core.
// Assumes program memory returns PROG_DATA one clock after PROG_ADDR.
`timescale 1ns/1ps
module cycle_core #(
  parameter int unsigned PC_W = 12,
  parameter int unsigned STACK_DEPTH = 8
) (
  input wire logic CLK, // System clock, 200 MHz
  input wire logic RST_N, // Asynchronous reset, active low
  output logic [PC_W-1:0] PROG_ADDR, // Program memory address
  input wire logic [15:0] PROG_DATA, // Program memory word, one clock late
  output logic CYCLE_END, // Last clock of an instruction cycle
  output logic [7:0] ACC, // Accumulator
  output core_pkg::flags_t FLAGS, // Zero and carry flags
  output logic INT_EN // Global interrupt enable, set by interrupt return
);
  localparam int unsigned SP_W = $clog2(STACK_DEPTH);

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [1:0] phase_reg;
  logic [PC_W-1:0] pc_reg, pc_next;
  core_pkg::instr_t ir_reg;
  logic ir_valid_reg;
  logic tbl_pend_reg;
  logic [7:0] tbl_dest_reg, tbl_low_reg, tbl_high_reg;
  logic [7:0] acc_reg, acc_next;
  core_pkg::flags_t flags_reg, flags_next;
  logic [7:0] tblp_reg, tblh_reg;
  logic int_en_reg;
  logic [PC_W-1:0] stack_reg [0:STACK_DEPTH-1];
  logic [SP_W-1:0] sp_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  logic last_clk, exec;
  logic [7:0] ram_rdata, rd_val, res;
  logic res_c, res_z_upd, res_c_upd, wr_acc, wr_mem, flow, skip_take, is_skip;
  logic push, pop, ram_we;
  logic [8:0] sum;
  logic [7:0] ram_wdata, ram_addr;
  logic [PC_W-1:0] tbl_addr;

  assign last_clk = phase_reg == core_pkg::PHASE_LAST;
  assign exec = last_clk && ir_valid_reg;
  assign tbl_addr = {pc_reg[PC_W-1:8], tblp_reg};
  // Bubble after a table read reads the table first, then refetches
  assign PROG_ADDR = (tbl_pend_reg && phase_reg < core_pkg::PHASE_FETCH) ? tbl_addr : pc_reg;
  assign ram_addr = ir_valid_reg ? ir_reg.m : tbl_dest_reg;
  function automatic logic [7:0] bit_mask(input logic [2:0] idx);
    bit_mask = 8'h01 << idx;
  endfunction
  function automatic logic is_special(input logic [7:0] a);
    is_special = (a == core_pkg::PC_LOW_ADDR) || (a == core_pkg::TBLP_ADDR) ||
                 (a == core_pkg::TBLH_ADDR);
  endfunction
  assign rd_val = (ir_reg.m == core_pkg::PC_LOW_ADDR) ? pc_reg[7:0] :
                  (ir_reg.m == core_pkg::TBLP_ADDR) ? tblp_reg :
                  (ir_reg.m == core_pkg::TBLH_ADDR) ? tblh_reg : ram_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Datapath
  always_comb begin
    res = rd_val;
    res_c = flags_reg.carry;
    res_z_upd = 1'b0;
    res_c_upd = 1'b0;
    wr_acc = 1'b0;
    wr_mem = 1'b0;
    is_skip = 1'b0;
    skip_take = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    sum = 9'h000;
    case (ir_reg.op)
      core_pkg::OP_MOV: begin
        res = ir_reg.dest ? acc_reg : rd_val;
        wr_acc = !ir_reg.dest;
        wr_mem = ir_reg.dest;
      end
      core_pkg::OP_MOVI: begin
        res = ir_reg.m;
        wr_acc = 1'b1;
      end
      core_pkg::OP_ADD, core_pkg::OP_SUB: begin
        sum = (ir_reg.op == core_pkg::OP_ADD) ? {1'b0, acc_reg} + {1'b0, rd_val}
                                              : {1'b0, acc_reg} - {1'b0, rd_val};
        res = sum[7:0];
        res_c = sum[8];
        res_c_upd = 1'b1;
        res_z_upd = 1'b1;
        wr_acc = !ir_reg.dest;
        wr_mem = ir_reg.dest;
      end
      core_pkg::OP_LOGIC: begin
        case (ir_reg.sub[1:0])
          core_pkg::LOG_AND: res = acc_reg & rd_val;
          core_pkg::LOG_OR: res = acc_reg | rd_val;
          core_pkg::LOG_XOR: res = acc_reg ^ rd_val;
          default: res = ~rd_val;
        endcase
        res_z_upd = 1'b1;
        wr_acc = !ir_reg.dest;
        wr_mem = ir_reg.dest;
      end
      core_pkg::OP_INCDEC: begin
        res = ir_reg.sub[0] ? rd_val - 8'h01 : rd_val + 8'h01;
        res_z_upd = 1'b1;
        wr_acc = !ir_reg.dest;
        wr_mem = ir_reg.dest;
      end
      core_pkg::OP_ROT: begin
        case (ir_reg.sub[1:0])
          core_pkg::ROT_RR: res = {rd_val[0], rd_val[7:1]};
          core_pkg::ROT_RL: res = {rd_val[6:0], rd_val[7]};
          core_pkg::ROT_RR_CARRY: res = {flags_reg.carry, rd_val[7:1]};
          default: res = {rd_val[6:0], flags_reg.carry};
        endcase
        res_c = ir_reg.sub[0] ? rd_val[7] : rd_val[0];
        res_c_upd = ir_reg.sub[1];
        wr_acc = !ir_reg.dest;
        wr_mem = ir_reg.dest;
      end
      core_pkg::OP_BCLR, core_pkg::OP_BSET: begin
        res = (ir_reg.op == core_pkg::OP_BSET) ? (rd_val | bit_mask(ir_reg.sub))
                                               : (rd_val & ~bit_mask(ir_reg.sub));
        wr_mem = 1'b1;
      end
      core_pkg::OP_SZ, core_pkg::OP_SNZ: begin
        is_skip = 1'b1;
        skip_take = (rd_val == 8'h00) == (ir_reg.op == core_pkg::OP_SZ);
      end
      core_pkg::OP_SBIT: begin
        is_skip = 1'b1;
        skip_take = rd_val[ir_reg.sub] == ir_reg.dest;
      end
      core_pkg::OP_CALL: push = 1'b1;
      core_pkg::OP_SYS: pop = ir_reg.m[3:0] != core_pkg::SYS_TABRD && !ir_reg.dest;
      default: res = rd_val;
    endcase
  end
  // Any change of flow, a written low PC byte or a taken skip costs a bubble
  assign flow = skip_take || push || pop || ir_reg.op == core_pkg::OP_JUMP ||
                ir_reg.op == core_pkg::OP_SYS ||
                (wr_mem && ir_reg.m == core_pkg::PC_LOW_ADDR);
  always_comb begin
    pc_next = pc_reg + PC_W'(1);
    if (exec) begin
      if (ir_reg.op == core_pkg::OP_JUMP || push) begin
        pc_next = PC_W'({ir_reg.dest, ir_reg.sub, ir_reg.m});
      end else if (pop) begin
        pc_next = stack_reg[sp_reg - SP_W'(1)];
      end else if (wr_mem && ir_reg.m == core_pkg::PC_LOW_ADDR) begin
        pc_next = {pc_reg[PC_W-1:8], res};
      end else if (skip_take) begin
        pc_next = pc_reg + PC_W'(1);
      end else if (flow) begin
        pc_next = pc_reg;
      end
    end
  end
  assign acc_next = (exec && wr_acc) ? res : acc_reg;
  assign flags_next.zero = (exec && res_z_upd) ? (res == 8'h00) : flags_reg.zero;
  assign flags_next.carry = (exec && res_c_upd) ? res_c : flags_reg.carry;
  assign ram_we = last_clk && (ir_valid_reg ? (wr_mem && !is_special(ir_reg.m))
                                            : (tbl_pend_reg && !is_special(tbl_dest_reg)));
  assign ram_wdata = ir_valid_reg ? res : tbl_low_reg;
  data_ram #(.AW(8), .DW(8)) data_ram_i (
    .clk(CLK),
    .addr(ram_addr),
    .we(ram_we),
    .wdata(ram_wdata),
    .rdata(ram_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      phase_reg <= core_pkg::PHASE_FIRST;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pc_reg <= '0;
      ir_reg <= '0;
      ir_valid_reg <= 1'b0;
      tbl_pend_reg <= 1'b0;
      tbl_dest_reg <= 8'h00;
      tbl_low_reg <= 8'h00;
      tbl_high_reg <= 8'h00;
    end else begin
      if (tbl_pend_reg && phase_reg == core_pkg::PHASE_TBL_DONE) begin
        tbl_low_reg <= PROG_DATA[7:0];
        tbl_high_reg <= PROG_DATA[15:8];
      end
      if (last_clk) begin
        pc_reg <= ir_valid_reg ? pc_next : pc_reg + PC_W'(1);
        ir_reg <= core_pkg::instr_t'(PROG_DATA);
        ir_valid_reg <= !(exec && flow);
        tbl_pend_reg <= exec && ir_reg.op == core_pkg::OP_SYS &&
                        ir_reg.dest == 1'b0 && ir_reg.sub == 3'h0 &&
                        pop == 1'b0;
        tbl_dest_reg <= ir_reg.m;
      end
    end
  end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      acc_reg <= core_pkg::ACC_RESET;
      flags_reg <= '0;
      tblp_reg <= core_pkg::TBLP_RESET;
      tblh_reg <= core_pkg::TBLH_RESET;
      int_en_reg <= core_pkg::INT_EN_RESET;
      sp_reg <= '0;
    end else if (last_clk) begin
      acc_reg <= acc_next;
      flags_reg <= flags_next;
      if (exec && wr_mem && ir_reg.m == core_pkg::TBLP_ADDR) begin
        tblp_reg <= res;
      end
      if (!ir_valid_reg && tbl_pend_reg) begin
        tblh_reg <= tbl_high_reg;
      end else if (exec && wr_mem && ir_reg.m == core_pkg::TBLH_ADDR) begin
        tblh_reg <= res;
      end
      if (exec && pop && ir_reg.m[3:0] == core_pkg::SYS_INT_RETURN) begin
        int_en_reg <= 1'b1;
      end
      if (exec && push) begin
        sp_reg <= sp_reg + SP_W'(1);
      end else if (exec && pop) begin
        sp_reg <= sp_reg - SP_W'(1);
      end
    end
  end
  // Overflow wraps and overwrites the oldest entry, as a small core stack does
  always_ff @(posedge CLK) begin
    if (exec && push) begin
      stack_reg[sp_reg] <= pc_reg;
    end
  end
  assign CYCLE_END = last_clk;
  assign ACC = acc_reg;
  assign FLAGS = flags_reg;
  assign INT_EN = int_en_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_cycle_four: assert property (@(posedge CLK) disable iff (!RST_N)
    last_clk |=> !last_clk [*3] ##1 last_clk) else $error("cycle not four clocks");
  chk_flow_bubble: assert property (@(posedge CLK) disable iff (!RST_N)
    (exec && flow) |=> !ir_valid_reg [*4] ##1 ir_valid_reg) else $error("flow without bubble");
  chk_plain_one: assert property (@(posedge CLK) disable iff (!RST_N)
    (exec && !flow) |=> ir_valid_reg [*4]) else $error("one-cycle instruction stalled");
  chk_low_pc_jump: assert property (@(posedge CLK) disable iff (!RST_N)
    (exec && wr_mem && ir_reg.m == core_pkg::PC_LOW_ADDR) |=> pc_reg[7:0] == $past(res))
    else $error("low pc write not taken");
  chk_skip_over: assert property (@(posedge CLK) disable iff (!RST_N)
    (exec && skip_take) |=> pc_reg == $past(pc_reg) + PC_W'(1)) else $error("skip not taken");
  chk_add_carry: assert property (@(posedge CLK) disable iff (!RST_N)
    (exec && ir_reg.op == core_pkg::OP_ADD) |=>
    flags_reg.carry == (({1'b0, $past(acc_reg)} + {1'b0, $past(rd_val)}) > 9'h0ff))
    else $error("carry mismatch");
  chk_zero_flag: assert property (@(posedge CLK) disable iff (!RST_N)
    (exec && ir_reg.op == core_pkg::OP_LOGIC) |=> flags_reg.zero == ($past(res) == 8'h00))
    else $error("zero flag mismatch");
  chk_bit_only: assert property (@(posedge CLK) disable iff (!RST_N)
    (ram_we && ir_valid_reg && ir_reg.op == core_pkg::OP_BSET) |->
    ((ram_wdata ^ rd_val) & ~bit_mask(ir_reg.sub)) == 8'h00) else $error("bit op spill");
  chk_call_return: assert property (@(posedge CLK) disable iff (!RST_N)
    (exec && push) |=> stack_reg[sp_reg - SP_W'(1)] == $past(pc_reg))
    else $error("return address lost");
  chk_tbl_write: assert property (@(posedge CLK) disable iff (!RST_N)
    (last_clk && !ir_valid_reg && tbl_pend_reg && ram_we) |->
    {tbl_high_reg, ram_wdata} == $past(PROG_DATA, 2)) else $error("table data not written");
  cov_skip: cover property (@(posedge CLK) disable iff (!RST_N) exec && skip_take);
  cov_call: cover property (@(posedge CLK) disable iff (!RST_N) exec && push);
  cov_table: cover property (@(posedge CLK) disable iff (!RST_N) last_clk && tbl_pend_reg);
endmodule

/* rtl/data_ram.sv */
// Single-port data memory with a registered read port.
// Assumes address is held stable for a clock before read data is used.
`timescale 1ns/1ps
module data_ram #(
  parameter int unsigned AW = 8,
  parameter int unsigned DW = 8
) (
  input wire logic clk, // Core clock
  input wire logic [AW-1:0] addr, // Word address
  input wire logic we, // Write strobe
  input wire logic [DW-1:0] wdata, // Write data
  output logic [DW-1:0] rdata // Registered read data
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule
